// >>> hdl/mac_irq_cfg_pkg.sv
// constants for the mac interrupt mask and receive config register bank
package mac_irq_cfg_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_RAW_STATUS = 8'h00; // mac_irq_raw_status
   localparam logic [7:0] OFF_MASKED_STATUS = 8'h04; // mac_irq_masked_status
   localparam logic [7:0] OFF_MASK_ENABLE = 8'h08; // mac_irq_mask_enable
   localparam logic [7:0] OFF_MASK_DISABLE = 8'h0c; // mac_irq_mask_disable
   localparam logic [7:0] OFF_RX_CFG = 8'h10; // rx_filter_channel_config
   // ==========================================================
   // interrupt field positions
   localparam int IRQ_W = 2; // number of mac event sources
   localparam int HOST_ERR_BIT = 1; // host_error_pending
   localparam int COUNTER_BIT = 0; // counter_threshold_pending
   localparam logic [1:0] IRQ_RESET = 2'h0; // status and mask after reset
   // ==========================================================
   // receive config field positions
   localparam int KEEP_FCS_BIT = 30; // keep_rx_fcs
   localparam int QOS_BIT = 29; // rx_qos_on
   localparam int SINGLE_BUF_BIT = 28; // single_buffer_rx
   localparam int COPY_CTRL_BIT = 24; // copy_control_frames
   localparam int COPY_SHORT_BIT = 23; // copy_short_frames
   localparam int COPY_ERR_BIT = 22; // copy_error_frames
   localparam int COPY_ALL_BIT = 21; // copy_all_frames
   localparam int CATCHALL_LSB = 16; // catchall_channel_sel
   localparam int BCAST_EN_BIT = 13; // broadcast receive enable
   localparam int BCAST_LSB = 8; // bcast_channel_sel
   localparam int MCAST_EN_BIT = 5; // multicast receive enable
   localparam int MCAST_LSB = 0; // mcast_channel_sel
   localparam int CH_W = 3; // channel select width
   localparam logic [31:0] RX_CFG_WMASK = 32'h71e7_2727; // writable bits
   localparam logic [31:0] RX_CFG_RESET = 32'h0000_0000; // config after reset
   // ==========================================================
   // frame check sequence and bus answers
   localparam int FCS_BYTES = 4; // trailing fcs length in bytes
   localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
   localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error
endpackage : mac_irq_cfg_pkg

// >>> hdl/mac_irq_bank.sv
// sticky mac event status, shared mask and level interrupt
`timescale 1ns/1ns
module mac_irq_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] event_in, // one-cycle event pulses
   input wire logic [1:0] raw_clr, // write-one-to-clear strobes
   input wire logic [1:0] mask_set, // enable strobes
   input wire logic [1:0] mask_clr, // disable strobes
   output logic [1:0] raw_r, // sticky raw status
   output logic [1:0] mask_r, // shared mask state
   output logic irq_r // level interrupt
);
   // ==========================================================
   // sticky status: an event in the clear cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_r <= mac_irq_cfg_pkg::IRQ_RESET;
      end else begin
         raw_r <= (raw_r & ~raw_clr) | event_in; // RULE1 RULE2
      end
   end

   // one mask state, set and cleared through two addresses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= mac_irq_cfg_pkg::IRQ_RESET; // RULE13
      end else begin
         mask_r <= (mask_r | mask_set) & ~mask_clr; // RULE5 RULE6 RULE7 RULE8 RULE12
      end
   end

   // interrupt high while any unmasked status bit stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(raw_r & mask_r); // RULE12
      end
   end
endmodule : mac_irq_bank

// >>> hdl/rx_fcs_len_adjust.sv
// descriptor length and fcs store decision per received frame
`timescale 1ns/1ns
module rx_fcs_len_adjust #(
   parameter int LEN_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic keep_fcs, // keep fcs in memory and length
   input wire logic frame_done, // frame length valid pulse
   input wire logic [LEN_W-1:0] frame_len, // bytes received incl fcs
   output logic [LEN_W-1:0] desc_len_r, // descriptor packet length
   output logic desc_valid_r, // pulse with desc_len_r
   output logic fcs_store_r // fcs bytes go to memory
);
   localparam logic [LEN_W-1:0] FCS_LEN = LEN_W'(mac_irq_cfg_pkg::FCS_BYTES);

   // ==========================================================
   // length seen by software, with or without the fcs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         desc_len_r <= '0;
         desc_valid_r <= 1'b0;
         fcs_store_r <= 1'b0;
      end else begin
         desc_valid_r <= frame_done;
         if (frame_done) begin
            fcs_store_r <= keep_fcs; // RULE9 RULE10
            if (keep_fcs) begin
               desc_len_r <= frame_len; // RULE10
            end else if (frame_len >= FCS_LEN) begin
               desc_len_r <= frame_len - FCS_LEN; // RULE9
            end else begin
               desc_len_r <= '0; // runt shorter than the fcs
            end
         end
      end
   end
endmodule : rx_fcs_len_adjust

// >>> hdl/mac_irq_mask_and_rx_crc_cfg.sv
// axi4-lite register bank: mac interrupt status and mask, receive config
//
// Notes on behaviour
// RULE1 - raw status bit 1 shows host error
// RULE2 - raw status bit 0 shows counter pending
// RULE3 - masked bit 1 is host error and mask
// RULE4 - masked bit 0 is counter and mask
// RULE5 - enable write one bit 1 unmasks host
// RULE6 - enable write one bit 0 unmasks counter
// RULE7 - disable write one bit 1 masks host
// RULE8 - disable write one bit 0 masks counter
// RULE9 - fcs bit zero drops fcs from length
// RULE10 - fcs bit one keeps fcs, counts it
// RULE11 - config bit 29 turns receive qos on
// RULE12 - one mask shared, both addresses read it
// RULE13 - reserved read zero, config resets zero
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module mac_irq_mask_and_rx_crc_cfg #(
   parameter int ADDR_W = 8,
   parameter int LEN_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [ADDR_W-1:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   input wire logic host_error_pending, // host error event pulse
   input wire logic counter_threshold_pending, // statistics event pulse
   input wire logic rx_frame_done, // frame length valid pulse
   input wire logic [LEN_W-1:0] rx_frame_len, // bytes incl fcs
   output logic irq,
   output logic [LEN_W-1:0] rx_desc_len,
   output logic rx_desc_valid,
   output logic rx_fcs_store,
   output logic keep_rx_fcs,
   output logic rx_qos_on,
   output logic single_buffer_rx,
   output logic copy_control_frames,
   output logic copy_short_frames,
   output logic copy_error_frames,
   output logic copy_all_frames,
   output logic bcast_frames_on,
   output logic mcast_frames_on,
   output logic [2:0] catchall_channel_sel,
   output logic [2:0] bcast_channel_sel,
   output logic [2:0] mcast_channel_sel
);
   // ==========================================================
   // elaboration checks
   initial begin
      if (ADDR_W < 5) $error("ADDR_W must reach the config offset");
      if (LEN_W < 3) $error("LEN_W must hold the fcs length");
   end

   // ==========================================================
   // state
   logic awready_r; // low while an address waits
   logic wready_r; // low while data waits
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [ADDR_W-1:0] aw_addr_r; // held write address
   logic [31:0] w_data_r; // held write data
   logic [3:0] w_strb_r; // held byte strobes
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [31:0] cfg_r; // receive config register
   logic [1:0] raw_r; // from the interrupt bank
   logic [1:0] mask_r;
   logic irq_r;
   logic wr_do; // both halves held, write happens now
   logic [31:0] wr_eff; // write data under byte strobes
   logic [1:0] raw_clr;
   logic [1:0] mask_set;
   logic [1:0] mask_clr;

   // ==========================================================
   // helpers
   // compare a bus address against a register offset
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      logic [ADDR_W-1:0] aligned;
      aligned = {a[ADDR_W-1:2], 2'h0};
      return aligned == ADDR_W'(off);
   endfunction : hit

   // expand byte strobes into a bit mask
   function automatic logic [31:0] lanes(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction : lanes

   // true for any mapped register
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return hit(a, mac_irq_cfg_pkg::OFF_RAW_STATUS) | hit(a, mac_irq_cfg_pkg::OFF_MASKED_STATUS)
         | hit(a, mac_irq_cfg_pkg::OFF_MASK_ENABLE) | hit(a, mac_irq_cfg_pkg::OFF_MASK_DISABLE)
         | hit(a, mac_irq_cfg_pkg::OFF_RX_CFG);
   endfunction : mapped

   // ==========================================================
   // write decode
   always_comb begin
      wr_do = !awready_r && !wready_r && !bvalid_r;
      wr_eff = w_data_r & lanes(w_strb_r);
      raw_clr = '0;
      mask_set = '0;
      mask_clr = '0;
      if (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_RAW_STATUS)) begin
         raw_clr = wr_eff[1:0]; // write one clears a sticky bit
      end
      if (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_MASK_ENABLE)) begin
         mask_set = wr_eff[1:0]; // RULE5 RULE6
      end
      if (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_MASK_DISABLE)) begin
         mask_clr = wr_eff[1:0]; // RULE7 RULE8
      end
   end

   // ==========================================================
   // write address channel, taken independently of data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         aw_addr_r <= '0;
      end else if (s_axil_awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_addr_r <= s_axil_awaddr;
      end else if (bvalid_r && s_axil_bready) begin
         awready_r <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b1;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axil_wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_data_r <= s_axil_wdata;
         w_strb_r <= s_axil_wstrb;
      end else if (bvalid_r && s_axil_bready) begin
         wready_r <= 1'b1;
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= mac_irq_cfg_pkg::RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r <= mapped(aw_addr_r) ? mac_irq_cfg_pkg::RESP_OKAY : mac_irq_cfg_pkg::RESP_SLVERR;
      end else if (s_axil_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ==========================================================
   // receive config register, writable fields only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= mac_irq_cfg_pkg::RX_CFG_RESET; // RULE13
      end else if (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_RX_CFG)) begin
         // reserved bits stay zero
         cfg_r <= (cfg_r & ~(lanes(w_strb_r) & mac_irq_cfg_pkg::RX_CFG_WMASK))
            | (wr_eff & mac_irq_cfg_pkg::RX_CFG_WMASK); // RULE11 RULE13
      end
   end

   // ==========================================================
   // read channel, data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= mac_irq_cfg_pkg::RESP_OKAY;
         rdata_r <= '0;
      end else if (s_axil_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= mapped(s_axil_araddr) ? mac_irq_cfg_pkg::RESP_OKAY : mac_irq_cfg_pkg::RESP_SLVERR;
         rdata_r <= '0; // reserved and unmapped read zero
         if (hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_RAW_STATUS)) begin
            rdata_r[1:0] <= raw_r; // RULE1 RULE2
         end else if (hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_MASKED_STATUS)) begin
            rdata_r[1:0] <= raw_r & mask_r; // RULE3 RULE4 RULE12
         end else if (hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_MASK_ENABLE)
            || hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_MASK_DISABLE)) begin
            rdata_r[1:0] <= mask_r; // RULE12
         end else if (hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_RX_CFG)) begin
            rdata_r <= cfg_r; // RULE13
         end
      end else if (rvalid_r && s_axil_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ==========================================================
   // submodules
   // sticky status, mask and interrupt level
   mac_irq_bank u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_in({host_error_pending, counter_threshold_pending}),
      .raw_clr(raw_clr),
      .mask_set(mask_set),
      .mask_clr(mask_clr),
      .raw_r(raw_r),
      .mask_r(mask_r),
      .irq_r(irq_r)
   );

   // fcs handling of descriptor length
   rx_fcs_len_adjust #(
      .LEN_W(LEN_W)
   ) u_fcs (
      .aclk(aclk),
      .aresetn(aresetn),
      .keep_fcs(cfg_r[mac_irq_cfg_pkg::KEEP_FCS_BIT]),
      .frame_done(rx_frame_done),
      .frame_len(rx_frame_len),
      .desc_len_r(rx_desc_len),
      .desc_valid_r(rx_desc_valid),
      .fcs_store_r(rx_fcs_store)
   );

   // ==========================================================
   // outputs, all from flops
   assign s_axil_awready = awready_r;
   assign s_axil_wready = wready_r;
   assign s_axil_bvalid = bvalid_r;
   assign s_axil_bresp = bresp_r;
   assign s_axil_arready = arready_r;
   assign s_axil_rvalid = rvalid_r;
   assign s_axil_rresp = rresp_r;
   assign s_axil_rdata = rdata_r;
   assign irq = irq_r;
   assign keep_rx_fcs = cfg_r[mac_irq_cfg_pkg::KEEP_FCS_BIT];
   assign rx_qos_on = cfg_r[mac_irq_cfg_pkg::QOS_BIT];
   assign single_buffer_rx = cfg_r[mac_irq_cfg_pkg::SINGLE_BUF_BIT];
   assign copy_control_frames = cfg_r[mac_irq_cfg_pkg::COPY_CTRL_BIT];
   assign copy_short_frames = cfg_r[mac_irq_cfg_pkg::COPY_SHORT_BIT];
   assign copy_error_frames = cfg_r[mac_irq_cfg_pkg::COPY_ERR_BIT];
   assign copy_all_frames = cfg_r[mac_irq_cfg_pkg::COPY_ALL_BIT];
   assign bcast_frames_on = cfg_r[mac_irq_cfg_pkg::BCAST_EN_BIT];
   assign mcast_frames_on = cfg_r[mac_irq_cfg_pkg::MCAST_EN_BIT];
   assign catchall_channel_sel = cfg_r[mac_irq_cfg_pkg::CATCHALL_LSB +: mac_irq_cfg_pkg::CH_W];
   assign bcast_channel_sel = cfg_r[mac_irq_cfg_pkg::BCAST_LSB +: mac_irq_cfg_pkg::CH_W];
   assign mcast_channel_sel = cfg_r[mac_irq_cfg_pkg::MCAST_LSB +: mac_irq_cfg_pkg::CH_W];

   // ==========================================================
   // assertions
   a_raw_host_set: assert property ( // RULE1
      @(posedge aclk) disable iff (!aresetn)
      host_error_pending |=> raw_r[1] ##1 (raw_r[1] || $past(raw_clr[1])))
      else $error("host error event not held in raw status");

   a_raw_counter_set: assert property ( // RULE2
      @(posedge aclk) disable iff (!aresetn)
      counter_threshold_pending |=> raw_r[0])
      else $error("counter event not shown in raw status");

   a_masked_host_read: assert property ( // RULE3
      @(posedge aclk) disable iff (!aresetn)
      (s_axil_arvalid && arready_r && hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_MASKED_STATUS))
      |=> s_axil_rvalid && (s_axil_rdata[1] == ($past(raw_r[1]) && $past(mask_r[1]))))
      else $error("masked host error read wrong");

   a_masked_counter_read: assert property ( // RULE4
      @(posedge aclk) disable iff (!aresetn)
      (s_axil_arvalid && arready_r && hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_MASKED_STATUS))
      |=> (s_axil_rdata[0] == ($past(raw_r[0]) && $past(mask_r[0]))))
      else $error("masked counter read wrong");

   a_mask_set_host: assert property ( // RULE5
      @(posedge aclk) disable iff (!aresetn)
      (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_MASK_ENABLE))
      |=> mask_r[1] == ($past(mask_r[1]) || $past(wr_eff[1])))
      else $error("host mask enable write wrong");

   a_mask_set_counter: assert property ( // RULE6
      @(posedge aclk) disable iff (!aresetn)
      (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_MASK_ENABLE) && wr_eff[0]) |=> mask_r[0] && bvalid_r)
      else $error("counter mask enable write lost");

   a_mask_clr_host: assert property ( // RULE7
      @(posedge aclk) disable iff (!aresetn)
      (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_MASK_DISABLE))
      |=> mask_r[1] == ($past(mask_r[1]) && !$past(wr_eff[1])))
      else $error("host mask disable write wrong");

   a_mask_clr_counter: assert property ( // RULE8
      @(posedge aclk) disable iff (!aresetn)
      (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_MASK_DISABLE))
      |=> mask_r[0] == ($past(mask_r[0]) && !$past(wr_eff[0])))
      else $error("counter mask disable write wrong");

   a_fcs_dropped: assert property ( // RULE9
      @(posedge aclk) disable iff (!aresetn)
      (rx_frame_done && !keep_rx_fcs && rx_frame_len >= LEN_W'(mac_irq_cfg_pkg::FCS_BYTES))
      |=> rx_desc_valid && !rx_fcs_store
         && rx_desc_len == $past(rx_frame_len) - LEN_W'(mac_irq_cfg_pkg::FCS_BYTES))
      else $error("fcs not removed from length");

   a_fcs_kept: assert property ( // RULE10
      @(posedge aclk) disable iff (!aresetn)
      (rx_frame_done && keep_rx_fcs) |=> rx_fcs_store && rx_desc_len == $past(rx_frame_len))
      else $error("fcs not kept in length");

   a_qos_write: assert property ( // RULE11
      @(posedge aclk) disable iff (!aresetn)
      (wr_do && hit(aw_addr_r, mac_irq_cfg_pkg::OFF_RX_CFG) && w_strb_r[3])
      |=> rx_qos_on == $past(w_data_r[29]))
      else $error("qos enable not written");

   a_irq_level: assert property ( // RULE12
      @(posedge aclk) disable iff (!aresetn)
      irq == $past(|(raw_r & mask_r)))
      else $error("interrupt level does not follow unmasked status");

   a_cfg_reserved: assert property ( // RULE13
      @(posedge aclk) disable iff (!aresetn)
      (s_axil_arvalid && arready_r && hit(s_axil_araddr, mac_irq_cfg_pkg::OFF_RX_CFG))
      |=> (s_axil_rdata & ~mac_irq_cfg_pkg::RX_CFG_WMASK) == 32'h0000_0000)
      else $error("reserved config bits read nonzero");
endmodule : mac_irq_mask_and_rx_crc_cfg

// >>> verif/mac_irq_mask_and_rx_crc_cfg_bench.sv
// self-checking bench for the mac interrupt mask and receive config register bank
`timescale 1ns/1ns
module mac_irq_mask_and_rx_crc_cfg_bench;
   // ==========================================================
   // clock, reset and design ports
   logic aclk = 1'b0; // 250 mhz clock
   logic aresetn = 1'b0; // held low for 20 cycles
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic host_err = 1'b0, cnt_pend = 1'b0, frame_done = 1'b0; // event and frame strobes
   logic [15:0] frame_len = 16'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, desc_valid, fcs_store;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] desc_len;
   wire [17:0] cfg_pins; // all config field outputs packed
   // ==========================================================
   // bench state
   int bad_count = 0; // mismatches
   int checked = 0; // comparisons
   logic [33:0] rd_q[$]; // expected read data and response
   logic [16:0] fr_q[$]; // expected fcs store and length
   logic [33:0] re;
   logic [16:0] fe;
   logic [31:0] seed = 32'h3d6305bf; // xorshift state
   logic [31:0] r;
   logic [31:0] r2;

   // free-running clock
   always #2 aclk = ~aclk;

   mac_irq_mask_and_rx_crc_cfg #(.ADDR_W(8), .LEN_W(16)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
      .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
      .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
      .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
      .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
      .host_error_pending(host_err), .counter_threshold_pending(cnt_pend),
      .rx_frame_done(frame_done), .rx_frame_len(frame_len), .irq(irq),
      .rx_desc_len(desc_len), .rx_desc_valid(desc_valid), .rx_fcs_store(fcs_store),
      .keep_rx_fcs(cfg_pins[17]), .rx_qos_on(cfg_pins[16]), .single_buffer_rx(cfg_pins[15]),
      .copy_control_frames(cfg_pins[14]), .copy_short_frames(cfg_pins[13]),
      .copy_error_frames(cfg_pins[12]), .copy_all_frames(cfg_pins[11]),
      .catchall_channel_sel(cfg_pins[10:8]), .bcast_frames_on(cfg_pins[7]),
      .bcast_channel_sel(cfg_pins[6:4]), .mcast_frames_on(cfg_pins[3]), .mcast_channel_sel(cfg_pins[2:0])
   );

   // ==========================================================
   // helpers
   // four-state compare, counts and reports
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // xorshift random source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // config word as seen on the field pins
   function automatic logic [31:0] pins(input logic [31:0] v);
      return {14'h0, v[30:28], v[24:21], v[18:16], v[13], v[10:8], v[5], v[2:0]};
   endfunction : pins

   // axi4-lite write, response code checked on its handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   // axi4-lite read, expectation noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      rd_q.push_back({e, er});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   // one-cycle event pulses, bit 1 host error, bit 0 counter
   task automatic pulse(input logic [1:0] b);
      host_err <= b[1];
      cnt_pend <= b[0];
      @(posedge aclk);
      host_err <= 1'b0;
      cnt_pend <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : pulse

   // back-to-back frames with a fixed fcs setting
   task automatic frames(input logic k);
      logic [15:0] l;
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         l = (i == 0) ? 16'h0003 : (i == 1) ? 16'h0004 : r[15:0];
         fr_q.push_back({k, k ? l : (l < 16'h4 ? 16'h0 : l - 16'h4)});
         frame_done <= 1'b1;
         frame_len <= l;
         @(posedge aclk);
      end
      frame_done <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : frames

   // verdict and end of run
   task automatic report_and_stop();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // monitor: oldest note against each result as it appears
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         re = rd_q.pop_front();
         chk("rdata", rdata, re[33:2]);
         chk("rresp", {30'h0, rresp}, {30'h0, re[1:0]});
      end
      if (desc_valid === 1'b1) begin
         fe = fr_q.pop_front();
         chk("desc len", {16'h0, desc_len}, {16'h0, fe[15:0]});
         chk("fcs store", {31'h0, fcs_store}, {31'h0, fe[16]});
      end
   end

   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      report_and_stop();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, mac_irq_cfg_pkg::RESP_OKAY);
      rd(8'h14, 32'h0, mac_irq_cfg_pkg::RESP_SLVERR);
      wr(8'h20, 32'hffffffff, 4'hf, mac_irq_cfg_pkg::RESP_SLVERR);
      // random config words, reserved bits read zero
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         wr(mac_irq_cfg_pkg::OFF_RX_CFG, r, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
         rd(mac_irq_cfg_pkg::OFF_RX_CFG, r & mac_irq_cfg_pkg::RX_CFG_WMASK, mac_irq_cfg_pkg::RESP_OKAY);
         chk("cfg pins", {14'h0, cfg_pins}, pins(r));
      end
      // top lane only: qos, fcs, single buffer and copy control bits change
      r2 = {8'hff, r[23:0]} & mac_irq_cfg_pkg::RX_CFG_WMASK;
      wr(mac_irq_cfg_pkg::OFF_RX_CFG, 32'hffffffff, 4'h8, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_RX_CFG, r2, mac_irq_cfg_pkg::RESP_OKAY);
      chk("cfg pins", {14'h0, cfg_pins}, pins(r2));
      // mask set, zero write ignored, shared view
      wr(mac_irq_cfg_pkg::OFF_MASK_ENABLE, 32'h1, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      wr(mac_irq_cfg_pkg::OFF_MASK_ENABLE, 32'h0, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_MASK_DISABLE, 32'h1, mac_irq_cfg_pkg::RESP_OKAY);
      pulse(2'b10);
      rd(mac_irq_cfg_pkg::OFF_RAW_STATUS, 32'h2, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_MASKED_STATUS, 32'h0, mac_irq_cfg_pkg::RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(mac_irq_cfg_pkg::OFF_MASK_ENABLE, 32'h2, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(mac_irq_cfg_pkg::OFF_MASKED_STATUS, 32'h2, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_MASK_ENABLE, 32'h3, mac_irq_cfg_pkg::RESP_OKAY);
      pulse(2'b01);
      rd(mac_irq_cfg_pkg::OFF_RAW_STATUS, 32'h3, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_MASKED_STATUS, 32'h3, mac_irq_cfg_pkg::RESP_OKAY);
      wr(mac_irq_cfg_pkg::OFF_MASK_DISABLE, 32'h1, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      wr(mac_irq_cfg_pkg::OFF_MASK_DISABLE, 32'h0, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_MASKED_STATUS, 32'h2, mac_irq_cfg_pkg::RESP_OKAY);
      wr(mac_irq_cfg_pkg::OFF_MASK_DISABLE, 32'h2, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, irq}, 32'h0);
      rd(mac_irq_cfg_pkg::OFF_MASK_ENABLE, 32'h0, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_RAW_STATUS, 32'h3, mac_irq_cfg_pkg::RESP_OKAY);
      wr(mac_irq_cfg_pkg::OFF_MASKED_STATUS, 32'hffffffff, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_MASKED_STATUS, 32'h0, mac_irq_cfg_pkg::RESP_OKAY);
      wr(mac_irq_cfg_pkg::OFF_RAW_STATUS, 32'h3, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      rd(mac_irq_cfg_pkg::OFF_RAW_STATUS, 32'h0, mac_irq_cfg_pkg::RESP_OKAY);
      // frame lengths with fcs dropped, then kept
      wr(mac_irq_cfg_pkg::OFF_RX_CFG, 32'h0, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      frames(1'b0);
      wr(mac_irq_cfg_pkg::OFF_RX_CFG, 32'h40000000, 4'hf, mac_irq_cfg_pkg::RESP_OKAY);
      frames(1'b1);
      chk("pending notes", 32'(rd_q.size() + fr_q.size()), 32'h0);
      report_and_stop();
   end
endmodule : mac_irq_mask_and_rx_crc_cfg_bench
